// ### urx_top.v
// Receive buffer, status flags and register slave of the serial port.
`timescale 1ns/10ps
`default_nettype none
`include "urx_defs.vh"

module urx_top (
   input  wire        aclk,              // System clock, 50 MHz.
   input  wire        aresetn,           // Synchronous reset, active low.
   input  wire [7:0]  awaddr,            // Write address.
   input  wire        awvalid,           // Write address valid.
   output reg         awready,           // Write address ready.
   input  wire [31:0] wdata,             // Write data.
   input  wire [3:0]  wstrb,             // Write byte strobes.
   input  wire        wvalid,            // Write data valid.
   output reg         wready,            // Write data ready.
   output reg  [1:0]  bresp,             // Write response.
   output reg         bvalid,            // Write response valid.
   input  wire        bready,            // Write response ready.
   input  wire [7:0]  araddr,            // Read address.
   input  wire        arvalid,           // Read address valid.
   output reg         arready,           // Read address ready.
   output reg  [31:0] rdata,             // Read data.
   output reg  [1:0]  rresp,             // Read response.
   output reg         rvalid,            // Read data valid.
   input  wire        rready,            // Read data ready.
   input  wire        serial_input_pin,  // Serial receive line.
   input  wire        global_irq_enable, // Global interrupt enable.
   output reg         rx_irq,            // Receive complete request.
   output reg         rx_pin_override    // Pin taken over by the receiver.
);
   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   reg         receive_complete_irq_enable;
   reg         receiver_enable;
   reg         parity_enable_bit;
   reg         parity_odd_select;
   reg         stop_bit_count_select;
   reg  [2:0]  character_size_code;
   reg  [15:0] baud_divisor;
   localparam [7:0] CTRL_RST = `URX_CTRL_RST;
   localparam [7:0] FMT_RST  = `URX_FMT_RST;

   // ****************************************************************
   // Input synchroniser
   // ****************************************************************
   reg         rx_meta;
   reg         rx_sync;

   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end else begin
         rx_meta <= serial_input_pin;
         rx_sync <= rx_meta;
      end
   end

   // ****************************************************************
   // Frame format decode
   // ****************************************************************
   reg  [3:0]  data_bits;
   reg  [8:0]  data_mask;
   integer     i;

   always @* begin
      data_mask = 9'h000;
      if (character_size_code == `URX_SIZE_NINE) begin
         data_bits = 4'h9;
      end else begin
         data_bits = {2'b00, character_size_code[1:0]} + 4'h5;
      end
      for (i = 0; i < 9; i = i + 1) begin
         data_mask[i] = (data_bits > i[3:0]);
      end
   end

   wire [3:0]  frame_bits = data_bits + {3'b000, parity_enable_bit} + 4'h1;

   // ****************************************************************
   // Shift register
   // ****************************************************************
   wire        start_det;
   wire        frame_done;
   wire [10:0] frame;

   urx_shift u_shift (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .enable     (receiver_enable),
      .rxd        (rx_sync),
      .divisor    (baud_divisor),
      .nbits      (frame_bits),
      .start_det  (start_det),
      .frame_done (frame_done),
      .frame      (frame)
   );

   // ****************************************************************
   // Frame checking
   // ****************************************************************
   wire [8:0]  rx_data    = frame[8:0] & data_mask;
   wire        rx_parity  = frame[data_bits];
   wire        rx_stop    = frame[data_bits + {3'b000, parity_enable_bit}];
   wire        parity_bad = parity_enable_bit &
                            (^rx_data ^ rx_parity ^ parity_odd_select);

   // ****************************************************************
   // Hold stage and overrun
   // ****************************************************************
   reg         hold_valid;
   reg  [11:0] hold_entry;
   reg         overrun_pending;
   wire [1:0]  fifo_count;
   wire [11:0] fifo_head;
   wire        fifo_full  = (fifo_count == `URX_FIFO_DEPTH);
   wire [11:0] new_entry  = {~rx_stop, overrun_pending, parity_bad, rx_data};
   wire        data_pop;
   reg         fifo_wr;
   reg  [11:0] fifo_wdata;

   // A waiting frame moves in first; a frame that finds no room waits in hold.
   always @* begin
      fifo_wr    = 1'b0;
      fifo_wdata = new_entry;
      if (hold_valid && !fifo_full) begin
         fifo_wr    = 1'b1;
         fifo_wdata = hold_entry;
      end else if (frame_done && !hold_valid && !fifo_full) begin
         fifo_wr    = 1'b1;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn || !receiver_enable) begin
         hold_valid      <= 1'b0;
         hold_entry      <= 12'h000;
         overrun_pending <= 1'b0;
      end else begin
         if (hold_valid && !fifo_full) begin
            hold_valid <= frame_done;
            hold_entry <= new_entry;
         end else if (frame_done && (hold_valid || fifo_full)) begin
            hold_valid <= 1'b1;
            hold_entry <= new_entry;
         end
         if (start_det && fifo_full && hold_valid) begin
            overrun_pending <= 1'b1;
         end else if (fifo_wr && frame_done && !hold_valid) begin
            overrun_pending <= 1'b0;
         end else if (hold_valid && !fifo_full && !frame_done) begin
            overrun_pending <= 1'b0;
         end
      end
   end

   urx_fifo u_fifo (
      .aclk    (aclk),
      .aresetn (aresetn),
      .flush   (~receiver_enable),
      .wr_en   (fifo_wr),
      .wr_data (fifo_wdata),
      .rd_en   (data_pop),
      .rd_data (fifo_head),
      .count   (fifo_count)
   );

   // ****************************************************************
   // Status view of the head frame
   // ****************************************************************
   wire        receive_complete_flag = (fifo_count != 2'h0);
   wire        frame_error_flag      = receive_complete_flag & fifo_head[`URX_E_FE];
   wire        overrun_flag          = receive_complete_flag & fifo_head[`URX_E_DOR];
   wire        parity_error_flag     = receive_complete_flag & parity_enable_bit &
                                       fifo_head[`URX_E_UPE];
   wire        received_ninth_bit    = receive_complete_flag & fifo_head[`URX_E_B8];

   // ****************************************************************
   // Register read mux
   // ****************************************************************
   reg  [31:0] rd_word;
   reg         rd_hit;

   always @* begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (araddr)
         `URX_OFF_STATUS: begin
            rd_word[`URX_ST_RXC] = receive_complete_flag;
            rd_word[`URX_ST_FE]  = frame_error_flag;
            rd_word[`URX_ST_DOR] = overrun_flag;
            rd_word[`URX_ST_UPE] = parity_error_flag;
         end
         `URX_OFF_CONTROL: begin
            rd_word[`URX_CT_IRQEN] = receive_complete_irq_enable;
            rd_word[`URX_CT_RXEN]  = receiver_enable;
            rd_word[`URX_CT_RX9]   = received_ninth_bit;
         end
         `URX_OFF_FORMAT: begin
            rd_word[`URX_FM_PEN]  = parity_enable_bit;
            rd_word[`URX_FM_PODD] = parity_odd_select;
            rd_word[`URX_FM_STOP] = stop_bit_count_select;
            rd_word[`URX_FM_SIZE_HI:`URX_FM_SIZE_LO] = character_size_code;
         end
         `URX_OFF_DATA: begin
            rd_word[7:0] = receive_complete_flag ? fifo_head[7:0] : 8'h00;
         end
         `URX_OFF_BAUD: begin
            rd_word[15:0] = baud_divisor;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   wire        ar_take = arvalid & arready;

   assign data_pop = ar_take & (araddr == `URX_OFF_DATA);

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `URX_RESP_OKAY;
      end else begin
         if (ar_take) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_hit ? `URX_RESP_OKAY : `URX_RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
         arready <= ~ar_take & (~rvalid | rready);
      end
   end

   // ****************************************************************
   // Write channel
   // ****************************************************************
   reg         aw_hold;
   reg  [7:0]  aw_addr;
   reg         w_hold;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg         next_aw_hold;
   reg         next_w_hold;
   reg         next_bvalid;
   wire        do_write = aw_hold & w_hold & ~bvalid;

   always @* begin
      next_aw_hold = (aw_hold | (awvalid & awready)) & ~do_write;
      next_w_hold  = (w_hold | (wvalid & wready)) & ~do_write;
      next_bvalid  = do_write | (bvalid & ~bready);
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= `URX_RESP_OKAY;
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         aw_hold <= next_aw_hold;
         w_hold  <= next_w_hold;
         bvalid  <= next_bvalid;
         awready <= ~next_aw_hold & ~next_bvalid;
         wready  <= ~next_w_hold & ~next_bvalid;
         if (awvalid && awready) begin
            aw_addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_data <= wdata;
            w_strb <= wstrb;
         end
         if (do_write) begin
            case (aw_addr)
               `URX_OFF_STATUS, `URX_OFF_CONTROL, `URX_OFF_FORMAT,
               `URX_OFF_DATA, `URX_OFF_BAUD: begin
                  bresp <= `URX_RESP_OKAY;
               end
               default: begin
                  bresp <= `URX_RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Register writes
   // ****************************************************************
   // Status bits are all hardware owned, so a status write changes nothing.
   always @(posedge aclk) begin
      if (!aresetn) begin
         receive_complete_irq_enable <= CTRL_RST[`URX_CT_IRQEN];
         receiver_enable             <= CTRL_RST[`URX_CT_RXEN];
         parity_enable_bit           <= FMT_RST[`URX_FM_PEN];
         parity_odd_select           <= FMT_RST[`URX_FM_PODD];
         stop_bit_count_select       <= FMT_RST[`URX_FM_STOP];
         character_size_code         <= FMT_RST[`URX_FM_SIZE_HI:`URX_FM_SIZE_LO];
         baud_divisor                <= `URX_BAUD_RST;
      end else if (do_write && w_strb[0]) begin
         case (aw_addr)
            `URX_OFF_CONTROL: begin
               receive_complete_irq_enable <= w_data[`URX_CT_IRQEN];
               receiver_enable             <= w_data[`URX_CT_RXEN];
            end
            `URX_OFF_FORMAT: begin
               parity_enable_bit     <= w_data[`URX_FM_PEN];
               parity_odd_select     <= w_data[`URX_FM_PODD];
               stop_bit_count_select <= w_data[`URX_FM_STOP];
               character_size_code   <= w_data[`URX_FM_SIZE_HI:`URX_FM_SIZE_LO];
            end
            `URX_OFF_BAUD: begin
               baud_divisor[7:0] <= w_data[7:0];
               if (w_strb[1]) begin
                  baud_divisor[15:8] <= w_data[15:8];
               end
            end
            `URX_OFF_STATUS: begin
               receive_complete_irq_enable <= receive_complete_irq_enable;
            end
            default: begin
               receiver_enable <= receiver_enable;
            end
         endcase
      end
   end

   // ****************************************************************
   // Interrupt request and pin ownership
   // ****************************************************************
   // Only the complete flag feeds the request; the error flags never do.
   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_irq          <= 1'b0;
         rx_pin_override <= 1'b0;
      end else begin
         rx_irq          <= receive_complete_flag & receive_complete_irq_enable &
                            global_irq_enable;
         rx_pin_override <= receiver_enable;
      end
   end
endmodule
`default_nettype wire

// ### urx_defs.vh
// Register map, field positions, reset values and codes of the receive block.
`ifndef URX_DEFS_VH
`define URX_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define URX_OFF_STATUS  8'h00
`define URX_OFF_CONTROL 8'h04
`define URX_OFF_FORMAT  8'h08
`define URX_OFF_DATA    8'h0c
`define URX_OFF_BAUD    8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define URX_ST_RXC      7
`define URX_ST_FE       4
`define URX_ST_DOR      3
`define URX_ST_UPE      2
`define URX_CT_IRQEN    7
`define URX_CT_RXEN     4
`define URX_CT_RX9      1
`define URX_FM_PEN      5
`define URX_FM_PODD     4
`define URX_FM_STOP     3
`define URX_FM_SIZE_HI  2
`define URX_FM_SIZE_LO  0
`define URX_E_FE        11
`define URX_E_DOR       10
`define URX_E_UPE       9
`define URX_E_B8        8

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define URX_CTRL_RST    8'h00
`define URX_FMT_RST     8'h03
`define URX_BAUD_RST    16'h01b2
`define URX_SIZE_NINE   3'h7
`define URX_FIFO_DEPTH  2'h2
`define URX_RESP_OKAY   2'h0
`define URX_RESP_SLVERR 2'h2

`endif

// ### urx_fifo.v
// Two-entry receive buffer memory with a registered head word.
`timescale 1ns/10ps
`default_nettype none
module urx_fifo (
   input  wire        aclk,     // System clock.
   input  wire        aresetn,  // Synchronous reset, active low.
   input  wire        flush,    // Empties the buffer.
   input  wire        wr_en,    // Stores wr_data.
   input  wire [11:0] wr_data,  // Entry to store.
   input  wire        rd_en,    // Drops the head entry.
   output reg  [11:0] rd_data,  // Head entry.
   output reg  [1:0]  count     // Number of entries held.
);
   reg  [11:0] mem [0:1];
   reg         wptr;
   reg         rptr;
   wire        do_wr     = wr_en & (count != `URX_FIFO_DEPTH);
   wire        do_rd     = rd_en & (count != 2'h0);
   wire        next_rptr = rptr ^ do_rd;

   always @(posedge aclk) begin
      if (do_wr) begin
         mem[wptr] <= wr_data;
      end
   end

   // The head word bypasses the memory when it is written in the same cycle.
   always @(posedge aclk) begin
      if (!aresetn || flush) begin
         wptr    <= 1'b0;
         rptr    <= 1'b0;
         count   <= 2'h0;
         rd_data <= 12'h000;
      end else begin
         wptr    <= wptr ^ do_wr;
         rptr    <= next_rptr;
         count   <= count + {1'b0, do_wr} - {1'b0, do_rd};
         rd_data <= (do_wr && (wptr == next_rptr)) ? wr_data : mem[next_rptr];
      end
   end
endmodule
`default_nettype wire

// ### urx_shift.v
// Receive shift register: start detection, bit-centre sampling, frame capture.
`timescale 1ns/10ps
`default_nettype none
module urx_shift (
   input  wire        aclk,        // System clock.
   input  wire        aresetn,     // Synchronous reset, active low.
   input  wire        enable,      // Receiver enable; low abandons the frame.
   input  wire        rxd,         // Synchronised serial input.
   input  wire [15:0] divisor,     // Clock cycles per bit.
   input  wire [3:0]  nbits,       // Data, parity and first stop bit count.
   output reg         start_det,   // Pulse on a confirmed start bit.
   output reg         frame_done,  // Pulse when the first stop bit is in.
   output reg  [10:0] frame        // Captured bits, first bit in bit 0.
);
   localparam ST_IDLE  = 2'h0;
   localparam ST_START = 2'h1;
   localparam ST_BITS  = 2'h2;

   reg [1:0]  state;
   reg [15:0] cnt;
   reg [3:0]  idx;
   reg        rxd_q;

   always @(posedge aclk) begin
      if (!aresetn || !enable) begin
         state      <= ST_IDLE;
         cnt        <= 16'h0000;
         idx        <= 4'h0;
         rxd_q      <= 1'b1;
         start_det  <= 1'b0;
         frame_done <= 1'b0;
         frame      <= 11'h000;
      end else begin
         rxd_q      <= rxd;
         start_det  <= 1'b0;
         frame_done <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (rxd_q && !rxd) begin
                  state <= ST_START;
                  cnt   <= divisor >> 1;
               end
            end
            ST_START: begin
               if (cnt != 16'h0000) begin
                  cnt <= cnt - 16'h0001;
               end else if (!rxd) begin
                  state     <= ST_BITS;
                  start_det <= 1'b1;
                  cnt       <= divisor - 16'h0001;
                  idx       <= 4'h0;
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_BITS: begin
               if (cnt != 16'h0000) begin
                  cnt <= cnt - 16'h0001;
               end else begin
                  frame[idx] <= rxd;
                  cnt        <= divisor - 16'h0001;
                  idx        <= idx + 4'h1;
                  // Sampling stops at the first stop bit; later stop bits are idle.
                  if (idx == nbits - 4'h1) begin
                     state      <= ST_IDLE;
                     frame_done <= 1'b1;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### urx_top_asserts.sv
// Checker for the register bus handshakes and the receive request outputs.
`timescale 1ns/10ps
`default_nettype none
`include "urx_defs.vh"
module urx_top_asserts (
   input wire logic        aclk,              // Clock.
   input wire logic        aresetn,           // Reset.
   input wire logic [7:0]  awaddr,            // Write address.
   input wire logic        awvalid,           // Write address valid.
   input wire logic        awready,           // Write address ready.
   input wire logic [31:0] wdata,             // Write data.
   input wire logic [3:0]  wstrb,             // Write strobes.
   input wire logic        wvalid,            // Write data valid.
   input wire logic        wready,            // Write data ready.
   input wire logic        bvalid,            // Response valid.
   input wire logic        bready,            // Response ready.
   input wire logic [7:0]  araddr,            // Read address.
   input wire logic        arvalid,           // Read address valid.
   input wire logic        arready,           // Read address ready.
   input wire logic [31:0] rdata,             // Read data.
   input wire logic        rvalid,            // Read data valid.
   input wire logic        rready,            // Read data ready.
   input wire logic        global_irq_enable, // Global enable.
   input wire logic        rx_irq,            // Request.
   input wire logic        rx_pin_override    // Pin override.
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] rd_addr;
   wire        wr_go = awvalid && awready && wvalid && wready;
   wire        ctl_go = wr_go && awaddr == `URX_OFF_CONTROL && wstrb[0];
   always @(posedge aclk) begin
      if (arvalid && arready) rd_addr <= araddr;
   end
   property p_b_hold; bvalid && !bready |=> bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
   property p_b_lat; wr_go |=> !bvalid ##1 bvalid; endproperty
   a_b_lat: assert property (p_b_lat) else $error("write response late");
   property p_r_lat; arvalid && arready |=> rvalid && !arready; endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
   property p_data_hi; rvalid && rd_addr == `URX_OFF_DATA |-> rdata[31:8] == 24'h0; endproperty
   a_data_hi: assert property (p_data_hi) else $error("data high bits set");
   property p_en; ctl_go && wdata[`URX_CT_RXEN] |-> ##[1:3] rx_pin_override; endproperty
   a_en: assert property (p_en) else $error("pin not taken");
   property p_dis; ctl_go && !wdata[`URX_CT_RXEN] |-> ##[1:4] !rx_pin_override && !rx_irq;
   endproperty
   a_dis: assert property (p_dis) else $error("disable not immediate");
   property p_gate; !global_irq_enable [*2] |-> !rx_irq; endproperty
   a_gate: assert property (p_gate) else $error("request not gated");
   c_irq: cover property (rx_irq);
   c_dis: cover property (ctl_go && !wdata[`URX_CT_RXEN]);
   c_dor: cover property (rvalid && rd_addr == `URX_OFF_STATUS && rdata[`URX_ST_DOR]);
endmodule
bind urx_top urx_top_asserts i_chk (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
   .wstrb, .wvalid, .wready, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rvalid,
   .rready, .global_irq_enable, .rx_irq, .rx_pin_override);
`default_nettype wire

// ### urx_uart_src.sv
// Remote serial transmitter model driving the receive line.
`timescale 1ns/10ps
`default_nettype none
module urx_uart_src #(
   parameter int DIV = 8 // Clock cycles per bit.
) (
   input  wire logic aclk, // System clock.
   output var  logic line  // Serial line, idle high.
);
   initial line = 1'b1;
   // Sends one frame LSB first; bad[0] flips parity, bad[1] zeroes the first stop bit.
   task automatic send(input logic [8:0] d, input int n, input logic pen, input logic podd,
                       input logic [1:0] bad, input int nstop);
      logic [15:0] f;
      int          k;
      int          len;
      f = '1;
      f[0] = 1'b0;
      for (k = 0; k < n; k++) f[k + 1] = d[k];
      len = n + 1;
      if (pen) begin
         f[len] = ^(d & ((9'h1 << n) - 9'h1)) ^ podd ^ bad[0];
         len++;
      end
      f[len] = ~bad[1];
      len = len + nstop + 1;
      for (k = 0; k < len; k++) begin
         line <= f[k];
         repeat (DIV) @(posedge aclk);
      end
   endtask
endmodule
`default_nettype wire

// ### urx_top_tb_top.sv
// Self-checking testbench of the receive block.
`timescale 1ns/10ps
`default_nettype none
`include "urx_defs.vh"
module urx_top_tb_top;
   logic        aclk = 1'b0, aresetn = 1'b0, global_irq_enable = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd;
   logic [1:0]  rs;
   wire         awready, wready, bvalid, arready, rvalid, rx_irq, rx_pin_override, line;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   int          err_count = 0, samples_checked = 0, k;
   always #10 aclk = ~aclk;
   urx_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .serial_input_pin(line), .global_irq_enable, .rx_irq, .rx_pin_override);
   urx_uart_src #(.DIV(8)) i_src (.aclk, .line);
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_out(input int n);
      if (n == 100) begin
         err_count++;
         $display("mismatch at %0t: bus wait ran out", $time);
         print_verdict;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      wait_out(n);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      wait_out(n);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      chk(rd, e);
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      global_irq_enable <= 1'b1;
      wr(`URX_OFF_BAUD, 32'h8);
      wr(`URX_OFF_FORMAT, 32'h2b);
      wr(`URX_OFF_CONTROL, 32'h90);
      rc(`URX_OFF_STATUS, 32'h0);
      chk({31'h0, rx_pin_override}, 32'h1);
      i_src.send(9'h0a5, 8, 1'b1, 1'b0, 2'b00, 2);
      i_src.send(9'h03c, 8, 1'b1, 1'b0, 2'b11, 2);
      chk({31'h0, rx_irq}, 32'h1);
      global_irq_enable <= 1'b0;
      repeat (3) @(posedge aclk);
      chk({31'h0, rx_irq}, 32'h0);
      global_irq_enable <= 1'b1;
      rc(`URX_OFF_STATUS, 32'h80);
      rc(`URX_OFF_DATA, 32'ha5);
      wr(`URX_OFF_STATUS, 32'h0);
      rc(`URX_OFF_STATUS, 32'h94);
      wr(`URX_OFF_FORMAT, 32'h0b);
      rc(`URX_OFF_STATUS, 32'h90);
      rc(`URX_OFF_DATA, 32'h3c);
      rc(`URX_OFF_STATUS, 32'h0);
      chk({31'h0, rx_irq}, 32'h0);
      wr(`URX_OFF_FORMAT, 32'h33);
      i_src.send(9'h001, 8, 1'b1, 1'b1, 2'b00, 1);
      rc(`URX_OFF_STATUS, 32'h80);
      rc(`URX_OFF_DATA, 32'h01);
      $display("error flag test done");
      wr(`URX_OFF_FORMAT, 32'h03);
      for (k = 0; k < 4; k++) i_src.send(9'h010 + k, 8, 1'b0, 1'b0, 2'b00, 1);
      rc(`URX_OFF_STATUS, 32'h80);
      rc(`URX_OFF_DATA, 32'h10);
      rc(`URX_OFF_STATUS, 32'h80);
      rc(`URX_OFF_DATA, 32'h11);
      rc(`URX_OFF_STATUS, 32'h88);
      rc(`URX_OFF_DATA, 32'h13);
      i_src.send(9'h020, 8, 1'b0, 1'b0, 2'b00, 1);
      rc(`URX_OFF_STATUS, 32'h80);
      rc(`URX_OFF_DATA, 32'h20);
      $display("overrun test done");
      wr(`URX_OFF_FORMAT, 32'h07);
      i_src.send(9'h1c3, 9, 1'b0, 1'b0, 2'b00, 1);
      rc(`URX_OFF_CONTROL, 32'h92);
      rc(`URX_OFF_DATA, 32'hc3);
      wr(`URX_OFF_FORMAT, 32'h02);
      i_src.send(9'h0ff, 7, 1'b0, 1'b0, 2'b00, 1);
      rc(`URX_OFF_DATA, 32'h7f);
      rc(8'h20, 32'h0);
      chk({30'h0, rs}, {30'h0, `URX_RESP_SLVERR});
      wr(8'h20, 32'h0);
      chk({30'h0, rs}, {30'h0, `URX_RESP_SLVERR});
      wr(`URX_OFF_STATUS, 32'h0);
      chk({30'h0, rs}, {30'h0, `URX_RESP_OKAY});
      $display("character size test done");
      wr(`URX_OFF_FORMAT, 32'h03);
      i_src.send(9'h055, 8, 1'b0, 1'b0, 2'b00, 1);
      fork
         i_src.send(9'h0aa, 8, 1'b0, 1'b0, 2'b00, 1);
         begin
            repeat (40) @(posedge aclk);
            wr(`URX_OFF_CONTROL, 32'h80);
         end
      join
      rc(`URX_OFF_STATUS, 32'h0);
      chk({30'h0, rx_irq, rx_pin_override}, 32'h0);
      wr(`URX_OFF_CONTROL, 32'h90);
      i_src.send(9'h066, 8, 1'b0, 1'b0, 2'b00, 1);
      rc(`URX_OFF_STATUS, 32'h80);
      rc(`URX_OFF_DATA, 32'h66);
      $display("receiver disable test done");
      print_verdict;
   end
endmodule
`default_nettype wire
